// file: shared/mfmsep_pkg.sv
// shared constants, types and helpers of the mfm data separator sequencer
package mfmsep_pkg;

    // apb register map, byte addresses of aligned 32-bit words
    localparam int APB_AW = 12;
    localparam logic [11:0] CTRL_OFS = 12'h000; // control word
    localparam logic [11:0] STAT_OFS = 12'h004; // live status word
    localparam logic [11:0] MCNT_OFS = 12'h008; // missing clock event counter

    // control word layout and reset value
    localparam int CTRL_REDUCED_BIT = 0; // reduced variant, no read delay option
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // status word layout
    localparam int STAT_STATE_LSB = 0; // four one-hot state bits
    localparam int STAT_LOCK_BIT = 4; // lock indication, active high here
    localparam int STAT_RDMODE_BIT = 5; // read mode entered
    localparam int STAT_BOOST_BIT = 6; // high tracking rate active
    localparam int STAT_RCSEL_BIT = 7; // read clock taken from the vco half rate
    localparam int STAT_PRE_LSB = 8; // preamble cell count, six bits

    // counter widths and reset values
    localparam int MCNT_W = 16;
    localparam logic [MCNT_W-1:0] MCNT_RST = 16'h0000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // read delay in vco cycles, long and bypassed
    localparam logic [5:0] DLY_LONG = 6'h20;
    localparam logic [5:0] DLY_SHORT = 6'h01;
    localparam logic [5:0] CNT6_ZERO = 6'h00;
    localparam logic [5:0] CNT6_ONE = 6'h01;

    // two bytes of preamble are sixteen data bits, thirty-two mfm cells
    localparam logic [5:0] PRE_CELLS = 6'h20;

    // clock one, data zero, suppressed clock, data zero, clock one
    localparam logic [4:0] MC_PATTERN = 5'h11;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_DELAY = 4'h2,
        ST_ACQ   = 4'h4,
        ST_LOCK  = 4'h8
    } mfmsep_state_e;

    // disk-side level inputs, sampled on pclk
    typedef struct packed {
        logic reference_clock_double_rate; // free running 2f reference
        logic vco_clk; // vco clock level
        logic enc_data; // encoded mfm read pulses, high per flux pulse
    } mfmsep_pins_s;

    // one-cycle rising edge of a sampled level
    function automatic logic mfmsep_rise(input logic cur, input logic prev);
        mfmsep_rise = cur & ~prev;
    endfunction : mfmsep_rise

endpackage : mfmsep_pkg

// file: hw/mfmsep_rdclk_mux.sv
// glitch-free changeover between the two read clock sources
`timescale 1ns/1ps
module mfmsep_rdclk_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_ref, // half rate reference clock level
    input wire logic src_vco, // half rate vco clock level
    input wire logic sel_vco, // wanted source, high for vco
    output logic rd_clk, // registered read clock
    output logic cur_vco // source actually in use
);
    import mfmsep_pkg::*;

    logic cur_vco_r; // source now followed
    logic park_r; // old source has gone low, output held low
    logic new_q_r; // wanted source one cycle ago, to catch its fall
    logic rd_clk_r; // output flop

    // the old source is followed until it falls, so its high phase is never cut
    wire old_v = cur_vco_r ? src_vco : src_ref;
    // the new one is taken only while low, so its first high phase is whole
    wire new_v = cur_vco_r ? src_ref : src_vco;
    wire same = (cur_vco_r == sel_vco);

    // last level of the wanted source; taking it only just after it falls keeps its low phase whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_q_r <= 1'b0;
        end else begin
            new_q_r <= new_v;
        end
    end

    // changeover sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_vco_r <= 1'b0;
            park_r <= 1'b0;
            rd_clk_r <= 1'b0;
        end else if (same) begin
            // steady, follow current source
            park_r <= 1'b0;
            rd_clk_r <= old_v;
        end else if (!park_r) begin
            // wait for the old source to fall
            rd_clk_r <= old_v;
            park_r <= ~old_v;
        end else begin
            // hold low until the new source falls, a low level alone does not end it
            rd_clk_r <= 1'b0;
            if (new_q_r && !new_v) begin
                cur_vco_r <= sel_vco;
                park_r <= 1'b0;
            end
        end
    end

    assign rd_clk = rd_clk_r;
    assign cur_vco = cur_vco_r;

endmodule : mfmsep_rdclk_mux

// file: hw/mfmsep_core.sv
// read-channel sequencer of an mfm data separator with an apb register port
//
// What this block does
// - delay off: read mode 32 vco cycles after request
// - delay bypassed: read mode after one vco cycle
// - reduced variant always acts as bypassed
// - pll fed half reference idle, data in read
// - comparator pulse only on valid input pulse
// - encoded data delayed half a reference period
// - preamble select chooses zeroes or ones pattern
// - lock output low after two preamble bytes
// - pattern break before lock restarts detection
// - lock command low selects low tracking rate
// - lock command switches read clock source
// - read clock changeover never shortens a period
// - lock command low enables mfm decoder
// - zeroes preamble keeps nrz output low
// - after lock flag any missing clock
// - missing clock flag lasts one read clock
// - flag aligned with last data bit output
// - outputs may lag one vco period
// - request low restores idle state and rate
// - abort within two read clocks of drop
`timescale 1ns/1ps
module mfmsep_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mfmsep_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mfmsep_pkg::mfmsep_pins_s pins,
    input wire logic read_gate,
    input wire logic delay_bypass,
    input wire logic preamble_zeroes,
    input wire logic lock_cmd_n,
    output logic lock_det_n,
    output logic pll_ref_data_sel,
    output logic phase_ref_pulse,
    output logic boost_current_pin,
    output logic low_rate_current_pin,
    output logic read_clk,
    output logic nrz_data,
    output logic missing_clk
);
    import mfmsep_pkg::*;

    // sampled previous levels for edge detection
    logic ref_q_r; // reference clock, last cycle
    logic vco_q_r; // vco clock, last cycle
    logic enc_q_r; // encoded data, last cycle
    logic rd_clk_q_r; // read clock, last cycle

    // divided clocks
    logic ref_half_r; // reference divided by two
    logic vco_half_r; // vco divided by two

    // sequencer
    mfmsep_state_e state_r;
    mfmsep_state_e state_nxt;
    logic [5:0] dly_cnt_r; // vco cycles since the request
    logic [5:0] dly_tgt_r; // delay chosen at the request

    // data path
    logic enc_pend_r; // pulse seen, waiting for the half period
    logic enc_dly_r; // pulse after half a reference period
    logic win_r; // pulse inside the current vco cell
    logic cell_ev_r; // one cell finished
    logic cell_bit_r; // value of that cell
    logic [4:0] cells_r; // most recent cells, newest in bit 0
    logic [5:0] pre_cnt_r; // alternating cells seen in a row
    logic phase_r; // high when the next cell is a clock cell

    // missing clock
    logic mc_pend_r; // detection waiting for a read clock edge
    logic [MCNT_W-1:0] mcnt_r; // events since software cleared

    // registers and output flops
    logic [31:0] ctrl_r;
    logic lock_det_n_r;
    logic pll_ref_sel_r;
    logic phase_ref_r;
    logic boost_r;
    logic low_rate_r;
    logic nrz_r;
    logic mc_flag_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // edge decode
    wire ref_rise = mfmsep_rise(pins.reference_clock_double_rate, ref_q_r);
    wire ref_fall = mfmsep_rise(ref_q_r, pins.reference_clock_double_rate);
    wire vco_rise = mfmsep_rise(pins.vco_clk, vco_q_r);
    wire enc_rise = mfmsep_rise(pins.enc_data, enc_q_r);
    wire rd_clk_w; // read clock from the changeover flop
    wire rc_vco_w; // source in use
    wire rd_rise = mfmsep_rise(rd_clk_w, rd_clk_q_r);

    // sequencer decode
    wire reduced = ctrl_r[CTRL_REDUCED_BIT];
    wire [5:0] dly_pick = (delay_bypass | reduced) ? DLY_SHORT : DLY_LONG;
    wire [5:0] dly_cnt_inc = dly_cnt_r + CNT6_ONE;
    wire read_mode = (state_r == ST_ACQ) || (state_r == ST_LOCK);
    wire locked_cmd = read_mode & ~lock_cmd_n;

    // preamble decode: every cell differs from the one before it
    wire alt = (cell_bit_r != cells_r[0]);
    wire pre_done = cell_ev_r && alt && (pre_cnt_r == PRE_CELLS - CNT6_ONE);
    // suppressed clock framed by two clock bits, checked on a clock cell
    wire [4:0] mc_win = {cells_r[3:0], cell_bit_r};
    wire mc_det = cell_ev_r && (state_r == ST_LOCK) && phase_r && (mc_win == MC_PATTERN);

    // apb decode
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_stat = (paddr == STAT_OFS);
    wire hit_mcnt = (paddr == MCNT_OFS);
    wire hit_any = hit_ctrl | hit_stat | hit_mcnt;
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pready_r & pwrite;
    wire [31:0] stat_w;
    wire [31:0] rd_mux;

    assign stat_w = {16'h0000, 2'h0, pre_cnt_r, rc_vco_w, boost_r, read_mode, ~lock_det_n_r, state_r};
    assign rd_mux = hit_ctrl ? ctrl_r :
                    hit_stat ? stat_w :
                    hit_mcnt ? {16'h0000, mcnt_r} : RDATA_ZERO;

    // next state; a dropped request aborts from any state at once
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (read_gate) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!read_gate) begin
                    state_nxt = ST_IDLE;
                end else if (vco_rise && dly_cnt_inc == dly_tgt_r) begin
                    state_nxt = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (!read_gate) begin
                    state_nxt = ST_IDLE;
                end else if (pre_done) begin
                    state_nxt = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (!read_gate) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // input sampling and clock halving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q_r <= 1'b0;
            vco_q_r <= 1'b0;
            enc_q_r <= 1'b0;
            rd_clk_q_r <= 1'b0;
            ref_half_r <= 1'b0;
            vco_half_r <= 1'b0;
        end else begin
            ref_q_r <= pins.reference_clock_double_rate;
            vco_q_r <= pins.vco_clk;
            enc_q_r <= pins.enc_data;
            rd_clk_q_r <= rd_clk_w;
            ref_half_r <= ref_half_r ^ ref_rise;
            vco_half_r <= vco_half_r ^ vco_rise;
        end
    end

    // sequencer and read delay counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            dly_cnt_r <= CNT6_ZERO;
            dly_tgt_r <= DLY_LONG;
        end else begin
            state_r <= state_nxt;
            // delay chosen when the request arrives
            if (state_r == ST_IDLE) begin
                dly_cnt_r <= CNT6_ZERO;
                dly_tgt_r <= dly_pick;
            end else if (state_r == ST_DELAY && vco_rise) begin
                dly_cnt_r <= dly_cnt_inc;
            end
        end
    end

    // half-period data delay, then capture into vco cells
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_pend_r <= 1'b0;
            enc_dly_r <= 1'b0;
            win_r <= 1'b0;
            cell_ev_r <= 1'b0;
            cell_bit_r <= 1'b0;
        end else begin
            // a pulse is released on the next falling reference edge, which
            // centres the decode window; a new pulse wins over the release
            enc_pend_r <= enc_rise | (enc_pend_r & ~ref_fall);
            enc_dly_r <= enc_pend_r & ref_fall;
            win_r <= enc_dly_r | (win_r & ~vco_rise);
            cell_ev_r <= vco_rise & read_mode;
            cell_bit_r <= win_r | enc_dly_r;
        end
    end

    // preamble detector and cell phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cells_r <= 5'h00;
            pre_cnt_r <= CNT6_ZERO;
            phase_r <= 1'b0;
        end else if (!read_mode) begin
            // nothing is searched before read mode
            cells_r <= 5'h00;
            pre_cnt_r <= CNT6_ZERO;
            phase_r <= 1'b0;
        end else if (cell_ev_r) begin
            cells_r <= mc_win;
            if (state_r == ST_ACQ) begin
                // any break in the alternation restarts the count
                pre_cnt_r <= alt ? pre_cnt_r + CNT6_ONE : CNT6_ZERO;
                // at lock the frame is fixed from the chosen pattern: with
                // zeroes a one is a clock cell, with ones it is a data cell
                phase_r <= preamble_zeroes ? ~cell_bit_r : cell_bit_r;
            end else begin
                phase_r <= ~phase_r;
            end
        end
    end

    // decoder, missing clock flag and event counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nrz_r <= 1'b0;
            mc_pend_r <= 1'b0;
            mc_flag_r <= 1'b0;
            mcnt_r <= MCNT_RST;
        end else begin
            // decoded bits only leave while locked and commanded; a zeroes
            // preamble decodes to zero, so the output stays low through it
            if (!locked_cmd || state_r != ST_LOCK) begin
                nrz_r <= 1'b0;
            end else if (cell_ev_r && !phase_r) begin
                nrz_r <= cell_bit_r;
            end
            // flag is raised and dropped on read clock rises, and dropped at once when read mode ends, so it is
            // one read clock long unless read mode ends first; a new detection wins the clear
            mc_pend_r <= mc_det | (mc_pend_r & ~rd_rise);
            if (!read_mode) begin
                mc_flag_r <= 1'b0;
            end else if (rd_rise) begin
                mc_flag_r <= mc_pend_r;
            end
            // software clears by writing; an event in that cycle still counts
            if (mc_det) begin
                mcnt_r <= (apb_wr && hit_mcnt) ? MCNT_RST + 1'b1 : mcnt_r + 1'b1;
            end else if (apb_wr && hit_mcnt) begin
                mcnt_r <= MCNT_RST;
            end
        end
    end

    // pll steering outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_det_n_r <= 1'b1;
            pll_ref_sel_r <= 1'b0;
            phase_ref_r <= 1'b0;
            boost_r <= 1'b1;
            low_rate_r <= 1'b1;
        end else begin
            lock_det_n_r <= (state_nxt != ST_LOCK);
            pll_ref_sel_r <= read_mode;
            // a comparator pulse only when the chosen input has one
            phase_ref_r <= read_mode ? enc_dly_r : (ref_rise & ~ref_half_r);
            // boost current only before the lock command
            boost_r <= ~locked_cmd;
            low_rate_r <= 1'b1;
        end
    end

    // apb slave, zero wait: answer is ready in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            prdata_r <= RDATA_ZERO;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~hit_any;
            prdata_r <= (apb_setup && !pwrite) ? rd_mux : RDATA_ZERO;
            if (apb_wr && hit_ctrl) begin
                ctrl_r <= {31'h0000_0000, pwdata[CTRL_REDUCED_BIT]};
            end
        end
    end

    // read clock source follows the lock command, changed without glitches
    mfmsep_rdclk_mux u_rdclk (
        .pclk(pclk),
        .presetn(presetn),
        .src_ref(ref_half_r),
        .src_vco(vco_half_r),
        .sel_vco(locked_cmd),
        .rd_clk(rd_clk_w),
        .cur_vco(rc_vco_w)
    );

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign lock_det_n = lock_det_n_r;
    assign pll_ref_data_sel = pll_ref_sel_r;
    assign phase_ref_pulse = phase_ref_r;
    assign boost_current_pin = boost_r;
    assign low_rate_current_pin = low_rate_r;
    assign read_clk = rd_clk_w;
    assign nrz_data = nrz_r;
    assign missing_clk = mc_flag_r;

endmodule : mfmsep_core

// file: dv/mfmsep_drive_model.sv
// model of the drive read stream and the loop clocks feeding the sequencer
`timescale 1ns/1ps
module mfmsep_drive_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cell_bit, // next mfm cell, high for a flux pulse
    output mfmsep_pkg::mfmsep_pins_s pins,
    output logic cell_tick // high in the same pclk as each vco rise, cell taken
);
    import mfmsep_pkg::*;
    logic [2:0] phase_r; // pclk count within one vco period
    logic cell_r; // cell being played out
    // free running counter; the reference never stops, reads or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 3'h0;
            cell_r <= 1'b0;
            cell_tick <= 1'b0;
        end else begin
            phase_r <= phase_r + 3'h1;
            cell_tick <= (phase_r == 3'h3);
            if (phase_r == 3'h3) begin
                cell_r <= cell_bit;
            end
        end
    end
    // field order: reference, vco, pulse in the middle of the cell so it never splits
    assign pins = {phase_r[1], phase_r[2], cell_r & (phase_r[2:1] == 2'h3)};
endmodule : mfmsep_drive_model

// file: dv/mfmsep_core_asserts.sv
// port level checks of the mfm separator sequencer
`timescale 1ns/1ps
module mfmsep_core_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mfmsep_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire mfmsep_pkg::mfmsep_pins_s pins,
    input wire logic read_gate,
    input wire logic delay_bypass,
    input wire logic preamble_zeroes,
    input wire logic lock_cmd_n,
    input wire logic lock_det_n,
    input wire logic pll_ref_data_sel,
    input wire logic phase_ref_pulse,
    input wire logic boost_current_pin,
    input wire logic low_rate_current_pin,
    input wire logic read_clk,
    input wire logic nrz_data,
    input wire logic missing_clk
);
    import mfmsep_pkg::*;
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [1:0] mc_rises; // read clock rises inside one flag pulse
    logic rc_q; // read clock one pclk ago
    logic mc_q; // flag one pclk ago
    // the opening rise is not counted, so a one-period flag ends on a count of one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_rises <= 2'h0;
            rc_q <= 1'b0;
            mc_q <= 1'b0;
        end else begin
            rc_q <= read_clk;
            mc_q <= missing_clk;
            mc_rises <= !missing_clk ? 2'h0 : mc_rises + 2'((mc_q && read_clk && !rc_q) && mc_rises != 2'h3);
        end
    end
    a_lock_in_read: assert property ($fell(lock_det_n) |-> pll_ref_data_sel)
        else $error("lock flagged outside read mode");
    a_abort_fast: assert property ($fell(read_gate) |-> ##[1:3] (!pll_ref_data_sel && lock_det_n))
        else $error("read not aborted in time");
    a_idle_ref: assert property (!read_gate [*3] |-> !pll_ref_data_sel)
        else $error("pll fed data while idle");
    a_rate_low: assert property ((!lock_cmd_n && pll_ref_data_sel) [*2] |-> !boost_current_pin)
        else $error("boost kept after lock command");
    a_rate_high: assert property (lock_cmd_n [*2] |-> boost_current_pin)
        else $error("boost missing without lock");
    a_rate_pin: assert property (boost_current_pin |-> low_rate_current_pin)
        else $error("boost without rate current");
    a_rdclk_high: assert property ($rose(read_clk) |-> read_clk [*3])
        else $error("short read clock high phase");
    a_rdclk_low: assert property ($fell(read_clk) |-> !read_clk [*3])
        else $error("short read clock low phase");
    a_pulse_one: assert property (phase_ref_pulse |=> !phase_ref_pulse)
        else $error("comparator pulse too long");
    a_nrz_idle: assert property (lock_cmd_n [*3] |-> !nrz_data)
        else $error("nrz active without lock");
    a_mc_locked: assert property ($rose(missing_clk) |-> !lock_det_n)
        else $error("missing clock flag before lock");
    a_mc_one_clk: assert property ($fell(missing_clk) |-> mc_rises == 2'h1)
        else $error("missing clock flag over one read clock");
    a_mc_min_len: assert property ($rose(missing_clk) |-> missing_clk [*6])
        else $error("missing clock flag too short");
endmodule : mfmsep_core_asserts
bind mfmsep_core mfmsep_core_asserts i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .read_gate(read_gate), .delay_bypass(delay_bypass),
    .preamble_zeroes(preamble_zeroes), .lock_cmd_n(lock_cmd_n), .lock_det_n(lock_det_n),
    .pll_ref_data_sel(pll_ref_data_sel), .phase_ref_pulse(phase_ref_pulse),
    .boost_current_pin(boost_current_pin), .low_rate_current_pin(low_rate_current_pin),
    .read_clk(read_clk), .nrz_data(nrz_data), .missing_clk(missing_clk));

// file: dv/tb.sv
// self-checking bench of the mfm separator sequencer
`timescale 1ns/1ps
module tb;
    import mfmsep_pkg::*;
    logic pclk = 1'b0; // 200 MHz
    logic presetn = 1'b0;
    logic [APB_AW-1:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, lock_det_n, pll_ref_data_sel, phase_ref_pulse, boost_current_pin;
    logic read_gate = 1'b0, delay_bypass = 1'b0, preamble_zeroes = 1'b1, cell_bit = 1'b0;
    logic low_rate_current_pin, read_clk, nrz_data, missing_clk, cell_tick, lock_cmd_n, mc_prev;
    mfmsep_pins_s pins;
    int fail_count = 0, compares = 0, vco_rises = 0, nrz_cnt = 0, mc_cnt = 0;
    assign lock_cmd_n = lock_det_n;
    always #2.5 pclk = ~pclk;
    // event tallies, non-blocking so scenarios read settled counts
    always @(posedge pclk) begin
        mc_prev <= missing_clk;
        vco_rises <= vco_rises + int'(cell_tick === 1'b1);
        nrz_cnt <= nrz_cnt + int'(nrz_data === 1'b1);
        mc_cnt <= mc_cnt + int'(missing_clk === 1'b1 && mc_prev === 1'b0);
    end
    mfmsep_drive_model i_drive (.pclk(pclk), .presetn(presetn), .cell_bit(cell_bit), .pins(pins),
        .cell_tick(cell_tick));
    mfmsep_core i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .read_gate(read_gate), .delay_bypass(delay_bypass), .preamble_zeroes(preamble_zeroes),
        .lock_cmd_n(lock_cmd_n), .lock_det_n(lock_det_n), .pll_ref_data_sel(pll_ref_data_sel),
        .phase_ref_pulse(phase_ref_pulse), .boost_current_pin(boost_current_pin),
        .low_rate_current_pin(low_rate_current_pin), .read_clk(read_clk), .nrz_data(nrz_data),
        .missing_clk(missing_clk));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // idle cycle, so a following setup never lands in the release step
    endtask : apb
    // one cell, held until the model reports it taken at a vco rise
    task automatic send_cell(input logic b);
        cell_bit <= b;
        do @(posedge pclk); while (cell_tick !== 1'b1);
    endtask : send_cell
    task automatic send_alt(input logic first, input int n);
        for (int i = 0; i < n; i++) send_cell(first ^ i[0]);
    endtask : send_alt
    task automatic wait_read;
        int k;
        k = 0;
        while (pll_ref_data_sel !== 1'b1 && k < 1000) begin
            @(posedge pclk);
            k++;
        end
    endtask : wait_read
    // drop the request; idle expected within four pclk
    task automatic abort;
        read_gate <= 1'b0;
        cell_bit <= 1'b0;
        repeat (4) @(posedge pclk);
        check({pll_ref_data_sel, lock_det_n, boost_current_pin, nrz_data, missing_clk}, 32'h0c);
    endtask : abort
    task automatic test_regs;
        logic [31:0] rd;
        logic er;
        apb(1'b0, CTRL_OFS, 32'h0, rd, er);
        check(rd, CTRL_RST);
        apb(1'b1, CTRL_OFS, 32'hffff_ffff, rd, er);
        apb(1'b0, CTRL_OFS, 32'h0, rd, er);
        check(rd, 32'h0000_0001);
        apb(1'b0, STAT_OFS, 32'h0, rd, er);
        check({18'h0, rd[13:0]}, 32'h41); // idle, boost on
        apb(1'b0, 12'h00c, 32'h0, rd, er);
        check({er, rd[30:0]}, 32'h8000_0000); // unmapped word refused
    endtask : test_regs
    task automatic test_delay(input logic byp, input logic red, input int lo, input int hi);
        logic [31:0] rd;
        logic er;
        int n0;
        apb(1'b1, CTRL_OFS, {31'h0, red}, rd, er);
        delay_bypass <= byp;
        read_gate <= 1'b1;
        n0 = vco_rises;
        wait_read();
        check({31'h0, vco_rises - n0 >= lo && vco_rises - n0 <= hi}, 32'h1);
        abort();
    endtask : test_delay
    task automatic test_lock(input logic zer);
        logic [31:0] rd;
        logic er;
        int n0;
        apb(1'b1, MCNT_OFS, 32'h0, rd, er); // any write clears the tally
        preamble_zeroes <= zer;
        delay_bypass <= 1'b1;
        read_gate <= 1'b1;
        wait_read();
        send_alt(zer, 40);
        check({lock_det_n, boost_current_pin}, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0, rd, er);
        check(rd[7:4], 32'hb); // locked, read mode, slow rate, vco clock
        n0 = nrz_cnt;
        send_alt(zer, 16);
        check({31'h0, nrz_cnt != n0}, {31'h0, ~zer});
        if (zer) begin
            n0 = mc_cnt;
            for (int i = 0; i < 5; i++) send_cell(i == 0 || i == 4);
            send_alt(1'b0, 15);
            check(mc_cnt - n0, 32'h1);
            apb(1'b0, MCNT_OFS, 32'h0, rd, er);
            check(rd, 32'h1);
        end
        abort();
    endtask : test_lock
    // a repeated one breaks the run; lock needs a fresh full preamble
    task automatic test_break;
        preamble_zeroes <= 1'b1;
        delay_bypass <= 1'b0;
        read_gate <= 1'b1;
        wait_read();
        send_alt(1'b1, 21);
        send_alt(1'b1, 24);
        check({31'h0, lock_det_n}, 32'h1);
        send_alt(1'b1, 12);
        check({31'h0, lock_det_n}, 32'h0);
        abort();
    endtask : test_break
    task automatic print_verdict;
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_regs();
        test_delay(1'b0, 1'b0, 32, 33);
        test_delay(1'b1, 1'b0, 1, 2);
        test_delay(1'b0, 1'b1, 1, 2);
        test_lock(1'b1);
        test_lock(1'b0);
        test_break();
        print_verdict();
    end
    // the scenarios need some 10 us; a hang is cut off well past that
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
endmodule : tb
